// ===== hw/upf_pkg.sv
// Purpose: shared constants of the external power switch control block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit byte address
// Notes:   offsets are byte addresses, one aligned word each
package upf_pkg;
    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL     = 12'h400; // control word
    localparam logic [11:0] OFS_RAW      = 12'h404; // raw fault status
    localparam logic [11:0] OFS_MASK     = 12'h408; // interrupt mask
    localparam logic [11:0] OFS_ISC      = 12'h40C; // masked status, w1c

    // ----------------------------------------------------------------
    // control word and status fields
    // ----------------------------------------------------------------
    localparam int          POS_MODE     = 0;  // enable_value_mode, 2 bits
    localparam int          POS_DRIVE    = 2;  // enable_output_drive_on
    localparam int          POS_RSVD     = 3;  // reserved, reads zero
    localparam int          POS_USE      = 4;  // fault_input_use
    localparam int          POS_SENSE    = 5;  // fault_sense_polarity
    localparam int          POS_ACT_EN   = 6;  // fault_action_enable
    localparam int          POS_ACT_SEL  = 8;  // fault_action_select, 2 bits
    localparam int          POS_FLAG     = 0;  // power_fault_flag in status

    // ----------------------------------------------------------------
    // field encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]  MODE_LOW     = 2'h0;
    localparam logic [1:0]  MODE_HIGH    = 2'h1;
    localparam logic [1:0]  MODE_NO_VBUS = 2'h2;
    localparam logic [1:0]  MODE_VBUS    = 2'h3;
    localparam logic [1:0]  ACT_KEEP     = 2'h0;
    localparam logic [1:0]  ACT_TRI      = 2'h1;
    localparam logic [1:0]  ACT_LOW      = 2'h2;
    localparam logic [1:0]  ACT_HIGH     = 2'h3;
    localparam logic [1:0]  RST_FIELD2   = 2'h0;
    localparam logic        RST_BIT      = 1'b0;
endpackage

// ===== hw/upf_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input is asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module upf_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,   // system clock
    input  wire logic         reset, // async, active high
    input  wire logic [W-1:0] d,     // asynchronous level
    output logic      [W-1:0] q      // synchronised level
);
    logic [W-1:0] meta;

    // metastability guard: nothing but q reads meta
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== hw/upf_ext_power_ctrl.sv
// Purpose: external power switch enable and power fault control
// Assumes: single 200 MHz clock, AXI4-Lite slave, vbus_valid on clk
// Notes:   fault override holds while the latched fault flag is set
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module upf_ext_power_ctrl (
    input  wire logic        clk,                      // 200 MHz
    input  wire logic        reset,                    // async, high
    input  wire logic [11:0] s_awaddr,                 // write address
    input  wire logic [2:0]  s_awprot,                 // unused
    input  wire logic        s_awvalid,                // aw valid
    output logic             s_awready,                // aw ready
    input  wire logic [31:0] s_wdata,                  // write data
    input  wire logic [3:0]  s_wstrb,                  // byte enables
    input  wire logic        s_wvalid,                 // w valid
    output logic             s_wready,                 // w ready
    output logic [1:0]       s_bresp,                  // write resp
    output logic             s_bvalid,                 // b valid
    input  wire logic        s_bready,                 // b ready
    input  wire logic [11:0] s_araddr,                 // read address
    input  wire logic [2:0]  s_arprot,                 // unused
    input  wire logic        s_arvalid,                // ar valid
    output logic             s_arready,                // ar ready
    output logic [31:0]      s_rdata,                  // read data
    output logic [1:0]       s_rresp,                  // read resp
    output logic             s_rvalid,                 // r valid
    input  wire logic        s_rready,                 // r ready
    input  wire logic        vbus_valid,               // VBUS seen
    input  wire logic        power_fault_in,           // fault pin
    output logic             power_switch_enable_out,  // enable level
    output logic             power_switch_enable_oe_n, // low = driven
    output logic             irq                       // level irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic        fault_action_enable;
    logic        fault_sense_polarity;
    logic        fault_input_use;
    logic        enable_output_drive_on;
    logic [1:0]  enable_value_mode;
    logic [1:0]  fault_action_select;
    logic        power_fault_flag;
    logic        fault_mask;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        fault_pin_s;
    logic        next_oe_n;
    logic        next_out;
    logic [31:0] ctrl_word;
    logic [31:0] rd_word;

    // ----------------------------------------------------------------
    // fault input path
    // ----------------------------------------------------------------
    upf_sync2 #(
        .W (1)
    ) u_fault_sync (
        .clk   (clk),
        .reset (reset),
        .d     (power_fault_in),
        .q     (fault_pin_s)
    );

    // polarity first, then the use gate
    wire fault_level = fault_sense_polarity ? fault_pin_s
                                            : !fault_pin_s;
    wire fault_qual  = fault_input_use && fault_level;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    // address and data may arrive in either order; both wait for b
    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready  = !w_held && !s_bvalid;
    wire        aw_fire = s_awvalid && s_awready;
    wire        w_fire  = s_wvalid && s_wready;
    wire        have_aw = aw_held || aw_fire;
    wire        have_w  = w_held || w_fire;
    wire        wr_go   = have_aw && have_w;
    wire [11:0] wa      = aw_held ? aw_addr : s_awaddr;
    wire [31:0] wd      = w_held ? w_data : s_wdata;
    wire [3:0]  ws      = w_held ? w_strb : s_wstrb;

    // word decode ignores the two low address bits
    wire w_ctrl = wa[11:2] == upf_pkg::OFS_CTRL[11:2];
    wire w_raw  = wa[11:2] == upf_pkg::OFS_RAW[11:2];
    wire w_mask = wa[11:2] == upf_pkg::OFS_MASK[11:2];
    wire w_isc  = wa[11:2] == upf_pkg::OFS_ISC[11:2];
    wire w_hit  = w_ctrl || w_raw || w_mask || w_isc;
    wire wr_b0  = wr_go && ws[0];
    wire wr_b1  = wr_go && ws[1];
    wire wr_clr = wr_b0 && w_isc && wd[upf_pkg::POS_FLAG];

    // hold whichever half arrived first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else if (wr_go) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
        end
    end

    // write response, one cycle after both halves are in
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_bvalid <= 1'b0;
            s_bresp  <= upf_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_bvalid <= 1'b1;
            s_bresp  <= w_hit ? upf_pkg::RESP_OKAY : upf_pkg::RESP_SLVERR;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // bit 3 has no storage, so writes to it vanish
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            enable_value_mode      <= upf_pkg::RST_FIELD2;
            enable_output_drive_on <= upf_pkg::RST_BIT;
            fault_input_use        <= upf_pkg::RST_BIT;
            fault_sense_polarity   <= upf_pkg::RST_BIT;
            fault_action_enable    <= upf_pkg::RST_BIT;
            fault_action_select    <= upf_pkg::RST_FIELD2;
            fault_mask             <= upf_pkg::RST_BIT;
        end else begin
            if (wr_b0 && w_ctrl) begin
                enable_value_mode      <= wd[upf_pkg::POS_MODE +: 2];
                enable_output_drive_on <= wd[upf_pkg::POS_DRIVE];
                fault_input_use        <= wd[upf_pkg::POS_USE];
                fault_sense_polarity   <= wd[upf_pkg::POS_SENSE];
                fault_action_enable    <= wd[upf_pkg::POS_ACT_EN];
            end
            if (wr_b1 && w_ctrl) begin
                fault_action_select <= wd[upf_pkg::POS_ACT_SEL +: 2];
            end
            if (wr_b0 && w_mask) begin
                fault_mask <= wd[upf_pkg::POS_FLAG];
            end
        end
    end

    // sticky fault flag: a fault in the clear cycle wins over the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_fault_flag <= 1'b0;
        end else begin
            power_fault_flag <= fault_qual
                             || (power_fault_flag && !wr_clr);
        end
    end

    assign irq = power_fault_flag && fault_mask;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign s_arready = !s_rvalid;
    wire ar_fire = s_arvalid && s_arready;
    wire r_ctrl  = s_araddr[11:2] == upf_pkg::OFS_CTRL[11:2];
    wire r_raw   = s_araddr[11:2] == upf_pkg::OFS_RAW[11:2];
    wire r_mask  = s_araddr[11:2] == upf_pkg::OFS_MASK[11:2];
    wire r_isc   = s_araddr[11:2] == upf_pkg::OFS_ISC[11:2];
    wire r_hit   = r_ctrl || r_raw || r_mask || r_isc;

    // control word assembly; reserved positions stay zero
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[upf_pkg::POS_MODE +: 2]    = enable_value_mode;
        ctrl_word[upf_pkg::POS_DRIVE]        = enable_output_drive_on;
        ctrl_word[upf_pkg::POS_USE]          = fault_input_use;
        ctrl_word[upf_pkg::POS_SENSE]        = fault_sense_polarity;
        ctrl_word[upf_pkg::POS_ACT_EN]       = fault_action_enable;
        ctrl_word[upf_pkg::POS_ACT_SEL +: 2] = fault_action_select;
    end

    // read mux, one source per word
    always_comb begin
        rd_word = 32'h0000_0000;
        if (r_ctrl) begin
            rd_word = ctrl_word;
        end else if (r_raw) begin
            rd_word[upf_pkg::POS_FLAG] = power_fault_flag;
        end else if (r_mask) begin
            rd_word[upf_pkg::POS_FLAG] = fault_mask;
        end else if (r_isc) begin
            rd_word[upf_pkg::POS_FLAG] = irq;
        end
    end

    // read data registered, answer one cycle after the address
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
            s_rresp  <= upf_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            s_rvalid <= 1'b1;
            s_rdata  <= rd_word;
            s_rresp  <= r_hit ? upf_pkg::RESP_OKAY : upf_pkg::RESP_SLVERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // enable output
    // ----------------------------------------------------------------
    // level selected by the enable mode
    logic mode_level;
    always_comb begin
        case (enable_value_mode)
            upf_pkg::MODE_LOW:     mode_level = 1'b0;
            upf_pkg::MODE_HIGH:    mode_level = 1'b1;
            upf_pkg::MODE_NO_VBUS: mode_level = !vbus_valid;
            upf_pkg::MODE_VBUS:    mode_level = vbus_valid;
            default:               mode_level = 1'b0;
        endcase
    end

    // override acts on the latched flag so a brief fault keeps the
    // selected fault action applied until software has cleared the flag
    wire override = fault_action_enable && power_fault_flag;

    always_comb begin
        next_oe_n = !enable_output_drive_on;
        next_out  = enable_output_drive_on && mode_level;
        if (override) begin
            case (fault_action_select)
                upf_pkg::ACT_KEEP: begin
                    next_oe_n = !enable_output_drive_on;
                    next_out  = enable_output_drive_on && mode_level;
                end
                upf_pkg::ACT_TRI: begin
                    next_oe_n = 1'b1;
                    next_out  = 1'b0;
                end
                upf_pkg::ACT_LOW: begin
                    next_oe_n = 1'b0;
                    next_out  = 1'b0;
                end
                upf_pkg::ACT_HIGH: begin
                    next_oe_n = 1'b0;
                    next_out  = 1'b1;
                end
                default: begin
                    next_oe_n = 1'b1;
                    next_out  = 1'b0;
                end
            endcase
        end
    end

    // undriven from reset: the switch sense is not yet known
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_switch_enable_oe_n <= 1'b1;
            power_switch_enable_out  <= 1'b0;
        end else begin
            power_switch_enable_oe_n <= next_oe_n;
            power_switch_enable_out  <= next_out;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic rd_was_ctrl;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_was_ctrl <= 1'b0;
        end else if (ar_fire) begin
            rd_was_ctrl <= r_ctrl;
        end
    end

    chk_keep_no_action: assert property (
        (!fault_action_enable && enable_output_drive_on
         && enable_value_mode == upf_pkg::MODE_HIGH)
        |=> (!power_switch_enable_oe_n && power_switch_enable_out))
        else $error("enable output not following mode with action off");
    chk_action_low: assert property (
        (override && fault_action_select == upf_pkg::ACT_LOW)
        |=> (!power_switch_enable_oe_n && !power_switch_enable_out))
        else $error("fault action low not applied");
    chk_action_high: assert property (
        (override && fault_action_select == upf_pkg::ACT_HIGH)
        |=> (!power_switch_enable_oe_n && power_switch_enable_out))
        else $error("fault action high not applied");
    chk_action_tri: assert property (
        (override && fault_action_select == upf_pkg::ACT_TRI)
        |=> power_switch_enable_oe_n)
        else $error("fault action tristate not applied");
    chk_sense_low: assert property (
        (fault_input_use && !fault_sense_polarity && !fault_pin_s)
        |=> power_fault_flag)
        else $error("low fault level not flagged");
    chk_sense_high: assert property (
        (fault_input_use && fault_sense_polarity && fault_pin_s)
        |=> power_fault_flag)
        else $error("high fault level not flagged");
    chk_unused_quiet: assert property (
        (!fault_input_use && !power_fault_flag && !wr_clr)
        |=> !power_fault_flag)
        else $error("fault flagged with input unused");
    chk_drive_off_hiz: assert property (
        (!enable_output_drive_on && !override) |=> power_switch_enable_oe_n)
        else $error("output driven while drive is off");
    chk_sync_two_flop: assert property (
        $past(reset, 2) == 1'b0 |-> fault_pin_s == $past(power_fault_in, 2))
        else $error("fault synchroniser delay wrong");
    chk_flag_clear: assert property (
        (wr_clr && !fault_qual) |=> !power_fault_flag)
        else $error("fault flag not cleared");
    chk_rsvd_zero: assert property (
        (s_rvalid && rd_was_ctrl) |-> s_rdata[upf_pkg::POS_RSVD] == 1'b0)
        else $error("reserved control bit read as one");

    cov_fault_override: cover property (override ##1 power_switch_enable_oe_n);
    cov_fault_clear:    cover property (power_fault_flag ##1 wr_clr ##1 !power_fault_flag);
    cov_vbus_mode:      cover property (enable_value_mode == upf_pkg::MODE_VBUS
                                        && enable_output_drive_on && vbus_valid);
endmodule

// ===== sim/upf_switch_model.sv
// Purpose: external load switch with a fault flag pin
// Assumes: flag pin rests at its inactive level outside an overload
// Notes:   undriven enable pin is biased off by a weak pull-down
`timescale 1ns/10ps
module upf_switch_model (
    input  wire logic clk,       // system clock
    input  wire logic en_out,    // enable level from the device
    input  wire logic en_oe_n,   // low = enable pin driven
    input  wire logic fault_req, // bench asks for an overload
    input  wire logic flag_high, // active level of the flag pin
    output logic      fault_pin, // flag pin to the device
    output logic      switch_on  // load switch state
);
    // pull-down wins when released, so a floating pin never powers the load
    assign switch_on = en_oe_n ? 1'b0 : en_out;
    // flag pin changes only on an edge, like a real switch's filtered flag
    always_ff @(posedge clk) begin
        fault_pin <= fault_req ? flag_high : !flag_high;
    end
endmodule

// ===== sim/tb.sv
// Purpose: self-checking bench for the power switch control block
// Assumes: fault pin settles into the flag within 6 cycles
// Notes:   expectations come from the bench model, never from the design
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; \
    if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
    logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, vbus, fault_req;
    logic        flag_high, fault_pin, en_out, en_oe_n, irq, sw_on, m_flag, m_mask;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, m_ctrl, c;
    logic [1:0]  bresp, rresp, r;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, k;

    upf_ext_power_ctrl dut_u (.clk(clk), .reset(reset),
        .s_awaddr(awaddr), .s_awprot(3'h0), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arprot(3'h0), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .vbus_valid(vbus), .power_fault_in(fault_pin), .power_switch_enable_out(en_out),
        .power_switch_enable_oe_n(en_oe_n), .irq(irq));
    upf_switch_model sw_u (.clk(clk), .en_out(en_out), .en_oe_n(en_oe_n),
        .fault_req(fault_req), .flag_high(flag_high), .fault_pin(fault_pin),
        .switch_on(sw_on));

    // --------------------------------------------------------------
    // clock, ceiling and closing report
    // --------------------------------------------------------------
    initial clk = 1'b0;
    always #2.5 clk = !clk;
    // the sweep needs about 1200 cycles; anything far beyond is a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic test_done();
        $display("counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // --------------------------------------------------------------
    // bus master and reference model
    // --------------------------------------------------------------
    // readies and answers are taken at the rising edge that the slave samples
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w, b;
        b = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            rs = bresp;
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar, rv;
        rv = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rv) begin
            @(posedge clk);
            ar = arvalid & arready;
            rv = rvalid;
            v = rdata;
            rs = rresp;
            if (ar) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic setc(input logic [31:0] v);
        axi_wr(upf_pkg::OFS_CTRL, v, r);
        `CHK("ctrl wr resp", upf_pkg::RESP_OKAY, r)
        m_ctrl = v & 32'h00000377;
        repeat (2) @(posedge clk);
    endtask
    // expected {oe_n, level}; latched flag overrides only with a non-keep action
    function automatic logic [1:0] exp_pin(input logic [31:0] cw, input logic f, input logic vb);
        logic lvl;
        lvl = cw[1] ? (cw[0] ? vb : !vb) : cw[0];
        if (cw[6] && f && cw[9:8] != 2'h0) return cw[9:8] == 2'h1 ? 2'h2 : {1'b0, cw[8]};
        return cw[2] ? {1'b0, lvl} : 2'h2;
    endfunction
    task automatic chk_pin();
        logic [1:0] e;
        @(negedge clk);
        e = exp_pin(m_ctrl, m_flag, vbus);
        `CHK("oe_n", e[1], en_oe_n)
        `CHK("enable", e[0], en_out)
        `CHK("switch", e[1] ? 1'b0 : e[0], sw_on)
        `CHK("irq", m_flag & m_mask, irq)
        @(posedge clk);
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, vbus, fault_req} = '0;
        flag_high = 1'b1;
        {awaddr, araddr, wdata} = '0;
        {m_ctrl, m_flag, m_mask} = '0;
        k = $urandom(32'hA082E2AB);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        axi_rd(upf_pkg::OFS_CTRL, d, r);
        `CHK("ctrl reset", 32'h0, d)
        chk_pin();
        setc(32'hFFFFFFFF);
        axi_rd(upf_pkg::OFS_CTRL, d, r);
        `CHK("ctrl rw", 32'h00000377, d)
        axi_wr(12'h500, 32'h1, r);
        `CHK("bad wr", upf_pkg::RESP_SLVERR, r)
        axi_rd(12'h500, d, r);
        `CHK("bad rd", upf_pkg::RESP_SLVERR, r)
        $display("test registers done");
        for (k = 0; k < 8; k++) begin
            vbus <= 1'($urandom);
            setc({29'h0, k[2:0]});
            chk_pin();
        end
        $display("test drive modes done");
        // every sense, use, action enable and action, mode picked at random
        for (k = 0; k < 32; k++) begin
            c = {22'h0, k[4:3], 1'b0, k[2], k[1], k[0], 2'h1, 2'($urandom)};
            fault_req <= 1'b0;
            flag_high <= k[1];
            vbus <= 1'($urandom);
            repeat (4) @(posedge clk);
            setc(c);
            axi_wr(upf_pkg::OFS_MASK, {31'h0, k[1]}, r);
            m_mask = k[1];
            axi_wr(upf_pkg::OFS_ISC, 32'h1, r);
            m_flag = 1'b0;
            fault_req <= 1'b1;
            repeat (6) @(posedge clk);
            m_flag = k[0];
            chk_pin();
            axi_rd(upf_pkg::OFS_RAW, d, r);
            `CHK("raw flag", {31'h0, m_flag}, d)
            axi_rd(upf_pkg::OFS_ISC, d, r);
            `CHK("masked flag", {31'h0, m_flag & m_mask}, d)
            fault_req <= 1'b0;
            repeat (6) @(posedge clk);
            axi_wr(upf_pkg::OFS_ISC, 32'h1, r);
            m_flag = 1'b0;
            axi_rd(upf_pkg::OFS_RAW, d, r);
            `CHK("flag clear", 32'h0, d)
            chk_pin();
        end
        $display("test fault actions done");
        test_done();
    end
endmodule
